// ---- hdl/adc_result_accumulate_window.sv ----
// Result formatting, burst accumulation and window detect behind AHB-Lite.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adc_acc_map.svh"
module adc_result_accumulate_window
  import adc_acc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter core
  input wire logic [9:0] sample_code,
  input wire logic sample_valid,
  output logic conv_start,
  output logic converter_power,
  output logic buffer_low_power,
  output logic temp_sensor_on,
  // Events
  output logic window_hit_flag
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic converter_on_bit_q;
  logic burst_enable_bit_q;
  logic temp_on_q;
  logic [2:0] repeat_count_sel_q;
  logic [2:0] shift_justify_sel_q;
  logic buf_lp_q;
  logic [3:0] power_up_time_q;
  logic [15:0] greater_q;
  logic [15:0] less_q;
  logic [15:0] result_q;
  logic hit_q;
  logic done_q;
  logic [15:0] acc_q;
  logic [6:0] count_q;
  logic [3:0] wait_q;
  logic start_q;
  logic power_q;
  burst_state_t state_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] samples_of(input logic [2:0] sel);
    case (sel)
      3'h1: samples_of = 7'h04;
      3'h2: samples_of = 7'h08;
      3'h3: samples_of = 7'h10;
      3'h4: samples_of = 7'h20;
      3'h5: samples_of = 7'h40;
      default: samples_of = 7'h01;
    endcase
  endfunction : samples_of

  function automatic logic [15:0] format_code(input logic [15:0] acc,
      input logic [2:0] sj);
    logic [15:0] r;
    r = 16'h0000;
    case (sj)
      3'h0: r = acc;
      3'h1: r = acc >> 1;
      3'h2: r = acc >> 2;
      3'h3: r = acc >> 3;
      `SJ_LEFT: r = acc << `LEFT_PAD;
      default: r = acc;
    endcase
    format_code = r;
  endfunction : format_code

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire logic addr_phase;
  wire logic do_write;
  wire logic do_read;
  wire logic [7:0] ofs;
  assign addr_phase = hsel && hready && htrans[1];
  assign do_write = addr_phase && hwrite;
  assign do_read = addr_phase && !hwrite;
  assign ofs = haddr[7:0];

  wire logic wr_ctrl;
  wire logic wr_fmt;
  wire logic wr_pwr;
  wire logic wr_gt;
  wire logic wr_lt;
  wire logic wr_stat;
  assign wr_ctrl = wr_pend_q && wr_addr_q == `OFS_CTRL;
  assign wr_fmt = wr_pend_q && wr_addr_q == `OFS_FORMAT;
  assign wr_pwr = wr_pend_q && wr_addr_q == `OFS_POWER;
  assign wr_gt = wr_pend_q && wr_addr_q == `OFS_GREATER;
  assign wr_lt = wr_pend_q && wr_addr_q == `OFS_LESS;
  assign wr_stat = wr_pend_q && wr_addr_q == `OFS_STATUS;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ofs == `OFS_CTRL) begin
      rd_mux[`CTRL_ON] = converter_on_bit_q;
      rd_mux[`CTRL_BURST] = burst_enable_bit_q;
      rd_mux[`CTRL_TEMP] = temp_on_q;
    end else if (ofs == `OFS_FORMAT) begin
      rd_mux[`FMT_RPT_LO +: 3] = repeat_count_sel_q;
      rd_mux[`FMT_SJ_LO +: 3] = shift_justify_sel_q;
    end else if (ofs == `OFS_POWER) begin
      rd_mux[`PWR_LPM] = buf_lp_q;
      rd_mux[`PWR_UP_LO +: 4] = power_up_time_q;
    end else if (ofs == `OFS_RESULT) begin
      rd_mux[15:0] = result_q;
    end else if (ofs == `OFS_GREATER) begin
      rd_mux[15:0] = greater_q;
    end else if (ofs == `OFS_LESS) begin
      rd_mux[15:0] = less_q;
    end else if (ofs == `OFS_STATUS) begin
      rd_mux[`STAT_HIT] = hit_q;
      rd_mux[`STAT_BUSY] = state_q != st_idle;
      rd_mux[`STAT_DONE] = done_q;
    end
  end

  // Writes land one cycle after the address phase, so slave is zero-wait.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= do_write;
      wr_addr_q <= ofs;
      if (do_read) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_on_bit_q <= 1'b0;
      burst_enable_bit_q <= 1'b0;
      temp_on_q <= 1'b0;
      repeat_count_sel_q <= 3'h0;
      shift_justify_sel_q <= 3'h0;
      buf_lp_q <= 1'b0;
      power_up_time_q <= `PWR_UP_RESET;
      greater_q <= 16'h0000;
      less_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        converter_on_bit_q <= hwdata[`CTRL_ON];
        burst_enable_bit_q <= hwdata[`CTRL_BURST];
        temp_on_q <= hwdata[`CTRL_TEMP];
      end
      if (wr_fmt) begin
        repeat_count_sel_q <= hwdata[`FMT_RPT_LO +: 3];
        shift_justify_sel_q <= hwdata[`FMT_SJ_LO +: 3];
      end
      if (wr_pwr) begin
        buf_lp_q <= hwdata[`PWR_LPM];
        power_up_time_q <= hwdata[`PWR_UP_LO +: 4];
      end
      if (wr_gt) begin
        greater_q <= hwdata[15:0];
      end
      if (wr_lt) begin
        less_q <= hwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Burst sequencer and accumulator
  // ---------------------------------------------------------------
  // A start while busy is ignored, as the converter would drop it anyway.
  wire logic start_req;
  wire logic [6:0] target;
  wire logic [15:0] acc_next;
  wire logic last_sample;
  assign start_req = wr_ctrl && hwdata[`CTRL_START] && state_q == st_idle;
  assign target = burst_enable_bit_q ? samples_of(repeat_count_sel_q) :
    7'h01;
  assign acc_next = acc_q + {6'h00, sample_code};
  assign last_sample = state_q == st_conv && sample_valid &&
    (count_q + 7'h01) == target;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= st_idle;
      acc_q <= 16'h0000;
      count_q <= 7'h00;
      wait_q <= 4'h0;
      start_q <= 1'b0;
      power_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        st_idle: begin
          power_q <= converter_on_bit_q;
          if (start_req) begin
            acc_q <= 16'h0000;
            count_q <= 7'h00;
            wait_q <= power_up_time_q;
            power_q <= 1'b1;
            if (converter_on_bit_q) begin
              state_q <= st_conv;
              start_q <= 1'b1;
            end else begin
              state_q <= st_power;
            end
          end
        end
        st_power: begin
          if (wait_q == 4'h0) begin
            state_q <= st_conv;
            start_q <= 1'b1;
          end else begin
            wait_q <= wait_q - 4'h1;
          end
        end
        st_conv: begin
          if (sample_valid) begin
            acc_q <= acc_next;
            count_q <= count_q + 7'h01;
            if (last_sample) begin
              state_q <= st_idle;
              power_q <= converter_on_bit_q;
            end else begin
              start_q <= 1'b1;
            end
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result and window flag
  // ---------------------------------------------------------------
  result_bus_if rb ();
  assign rb.code = format_code(acc_next, shift_justify_sel_q);
  assign rb.update = last_sample;
  assign rb.greater = greater_q;
  assign rb.less = less_q;

  window_compare u_cmp (
    .rb(rb)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 16'h0000;
      hit_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (last_sample) begin
        result_q <= rb.code;
      end
      // Set beats a simultaneous software clear.
      if (rb.hit) begin
        hit_q <= 1'b1;
      end else if (wr_stat && hwdata[`STAT_HIT]) begin
        hit_q <= 1'b0;
      end
      if (last_sample) begin
        done_q <= 1'b1;
      end else if (wr_stat && hwdata[`STAT_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conv_start = start_q;
  assign converter_power = power_q;
  assign buffer_low_power = buf_lp_q;
  assign temp_sensor_on = temp_on_q;
  assign window_hit_flag = hit_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_result_left_pad: assert property (@(posedge hclk)
    disable iff (!hresetn) last_sample && shift_justify_sel_q == `SJ_LEFT
    |=> result_q[5:0] == 6'h00) else $error("left result low bits not zero");
  a_hit_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    hit_q && !(wr_stat && hwdata[`STAT_HIT]) |=> hit_q)
    else $error("hit flag cleared by hardware");
  a_hit_strict: assert property (@(posedge hclk) disable iff (!hresetn)
    last_sample && (rb.code == greater_q || rb.code == less_q) &&
    !(wr_stat && hwdata[`STAT_HIT]) |=> hit_q == $past(hit_q))
    else $error("equal code changed flag");
  a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !last_sample |=> $stable(result_q))
    else $error("result changed mid series");
  a_power_once: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == st_conv |=> state_q != st_power)
    else $error("power delay repeated in burst");
  a_idle_off: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == st_idle && !converter_on_bit_q && !start_req |=> !power_q)
    else $error("converter powered while idle");
  a_acc_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
    start_req |=> acc_q == 16'h0000) else $error("acc not cleared");
  a_result_value: assert property (@(posedge hclk)
    disable iff (!hresetn) last_sample |=>
    result_q == format_code($past(acc_next), $past(shift_justify_sel_q)))
    else $error("result mismatch");
  a_count_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == st_conv |-> count_q < target)
    else $error("sample count overran");
endmodule : adc_result_accumulate_window
`default_nettype wire

// ---- hdl/adc_acc_map.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef ADC_ACC_MAP_SVH
`define ADC_ACC_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_FORMAT 8'h04
`define OFS_POWER 8'h08
`define OFS_RESULT 8'h0C
`define OFS_GREATER 8'h10
`define OFS_LESS 8'h14
`define OFS_STATUS 8'h18
`define OFS_SAMPLE 8'h1C
`define CTRL_ON 0
`define CTRL_BURST 1
`define CTRL_TEMP 2
`define CTRL_START 3
`define FMT_RPT_LO 0
`define FMT_SJ_LO 3
`define PWR_LPM 4
`define PWR_UP_LO 0
`define PWR_UP_RESET 4'hF
`define STAT_HIT 0
`define STAT_BUSY 1
`define STAT_DONE 2
`define SJ_LEFT 3'h4
`define SAMPLE_BITS 10
`define LEFT_PAD 6
`endif

// ---- hdl/adc_acc_pkg.sv ----
// Types shared by the result accumulator block.
package adc_acc_pkg;
  typedef enum logic [1:0] {st_idle, st_power, st_conv} burst_state_t;
  typedef logic [15:0] word16_t;
endpackage : adc_acc_pkg

// ---- hdl/result_bus_if.sv ----
// Interface carrying window limits and a new result to the comparator.
`timescale 1ns/1ns
`default_nettype none
interface result_bus_if;
  logic [15:0] code;
  logic update;
  logic [15:0] greater;
  logic [15:0] less;
  logic hit;
  modport src (output code, output update, output greater, output less,
    input hit);
  modport cmp (input code, input update, input greater, input less,
    output hit);
endinterface : result_bus_if
`default_nettype wire

// ---- hdl/window_compare.sv ----
// Strict window comparator on each newly completed result.
`timescale 1ns/1ns
`default_nettype none
module window_compare
  import adc_acc_pkg::*;
(
  result_bus_if.cmp rb
);
  wire logic above;
  wire logic below;
  wire logic inside_mode;
  // Codes equal to a limit never hit.
  assign above = rb.code > rb.greater;
  assign below = rb.code < rb.less;
  assign inside_mode = rb.less > rb.greater;
  assign rb.hit = rb.update &&
    (inside_mode ? (above && below) : (above || below));
endmodule : window_compare
`default_nettype wire

// ---- dv/adc_result_accumulate_window_test.sv ----
// Self-checking bench for result formatting, accumulation and window detect.
`timescale 1ns/1ns
`default_nettype none
`include "adc_acc_map.svh"
module adc_result_accumulate_window_test
  import adc_acc_pkg::*;
();
  typedef struct {
    logic [7:0] fmt;
    logic [9:0] code;
    word16_t gt;
    word16_t lt;
    word16_t res;
    logic hit;
  } row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic sample_valid = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] sample_code = 10'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic conv_start;
  logic converter_power;
  logic buffer_low_power;
  logic temp_sensor_on;
  logic window_hit_flag;
  int n_errors = 0;
  int cmp_count = 0;
  int counts[8] = '{1, 4, 8, 16, 32, 64, 1, 1};
  int pup = `PWR_UP_RESET;
  // Format rows first, then window rows; limits FFFF/0000 never hit.
  row_t rows[23] = '{
    '{8'h00, 10'h3FF, 16'hFFFF, 16'h0000, 16'h03FF, 1'b0},
    '{8'h20, 10'h3FF, 16'hFFFF, 16'h0000, 16'hFFC0, 1'b0},
    '{8'h20, 10'h200, 16'hFFFF, 16'h0000, 16'h8000, 1'b0},
    '{8'h00, 10'h100, 16'hFFFF, 16'h0000, 16'h0100, 1'b0},
    '{8'h01, 10'h3FF, 16'hFFFF, 16'h0000, 16'h0FFC, 1'b0},
    '{8'h03, 10'h3FF, 16'hFFFF, 16'h0000, 16'h3FF0, 1'b0},
    '{8'h05, 10'h3FF, 16'hFFFF, 16'h0000, 16'hFFC0, 1'b0},
    '{8'h02, 10'h1FF, 16'hFFFF, 16'h0000, 16'h0FF8, 1'b0},
    '{8'h04, 10'h100, 16'hFFFF, 16'h0000, 16'h2000, 1'b0},
    '{8'h09, 10'h3FF, 16'hFFFF, 16'h0000, 16'h07FE, 1'b0},
    '{8'h13, 10'h200, 16'hFFFF, 16'h0000, 16'h0800, 1'b0},
    '{8'h1D, 10'h1FF, 16'hFFFF, 16'h0000, 16'h0FF8, 1'b0},
    '{8'h06, 10'h0AA, 16'hFFFF, 16'h0000, 16'h00AA, 1'b0},
    '{8'h00, 10'h080, 16'h0080, 16'h0000, 16'h0080, 1'b0},
    '{8'h00, 10'h081, 16'h0080, 16'h0000, 16'h0081, 1'b1},
    '{8'h00, 10'h040, 16'h0040, 16'h0080, 16'h0040, 1'b0},
    '{8'h00, 10'h041, 16'h0040, 16'h0080, 16'h0041, 1'b1},
    '{8'h00, 10'h080, 16'h0040, 16'h0080, 16'h0080, 1'b0},
    '{8'h00, 10'h03F, 16'h03FF, 16'h0040, 16'h003F, 1'b1},
    '{8'h00, 10'h040, 16'h03FF, 16'h0040, 16'h0040, 1'b0},
    '{8'h00, 10'h060, 16'h0080, 16'h0040, 16'h0060, 1'b0},
    '{8'h00, 10'h3FF, 16'h0080, 16'h0040, 16'h03FF, 1'b1},
    '{8'h01, 10'h050, 16'h0000, 16'h0100, 16'h0140, 1'b0}
  };

  adc_result_accumulate_window i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .sample_code(sample_code),
    .sample_valid(sample_valid),
    .conv_start(conv_start),
    .converter_power(converter_power),
    .buffer_low_power(buffer_low_power),
    .temp_sensor_on(temp_sensor_on),
    .window_hit_flag(window_hit_flag)
  );

  always #50 hclk = ~hclk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  // One single word transfer; read data is taken at the data phase edge.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 0, hresp);
    // Let register outputs settle before any caller looks at them.
    @(negedge hclk);
  endtask : bus

  // Starts a series and answers every conversion request with a sample.
  task run(input logic [7:0] fmt, input logic [9:0] code, input logic [3:0] c);
    int k;
    int n;
    logic pwr;
    bus(1'b1, `OFS_FORMAT, {24'h0, fmt});
    pwr = converter_power;
    n = c[`CTRL_BURST] ? counts[fmt[2:0]] : 1;
    bus(1'b1, `OFS_CTRL, {28'h0, c});
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(posedge hclk);
      while (conv_start !== 1'b1 && k < 60) begin
        @(posedge hclk);
        k++;
      end
      if (k == 60) chk("conv_start", 1, 0);
      if (i > 0) chk("sample spacing", 0, 32'(k));
      else chk("first sample wait", pwr ? 0 : pup + 1, 32'(k));
      chk("converter_power", 1, converter_power);
      sample_valid <= 1'b1;
      sample_code <= code;
      @(posedge hclk);
      sample_valid <= 1'b0;
      sample_code <= ~code;
    end
    @(negedge hclk);
  endtask : run

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `OFS_POWER, 0);
    chk("power reset", {28'h0, `PWR_UP_RESET}, rd);
    bus(1'b0, 8'h20, 0);
    chk("unmapped read", 0, rd);
    chk("converter_power idle", 0, converter_power);
    foreach (rows[i]) begin
      bus(1'b1, `OFS_GREATER, {16'h0, rows[i].gt});
      bus(1'b1, `OFS_LESS, {16'h0, rows[i].lt});
      bus(1'b1, `OFS_STATUS, 32'h5);
      run(rows[i].fmt, rows[i].code, 4'hB);
      bus(1'b0, `OFS_RESULT, 0);
      chk("result", {16'h0, rows[i].res}, rd);
      chk("window_hit_flag", rows[i].hit, window_hit_flag);
      bus(1'b0, `OFS_STATUS, 0);
      chk("status hit", rows[i].hit, rd[`STAT_HIT]);
      chk("status done", 1, rd[`STAT_DONE]);
    end
    // The flag survives a later miss and only a software clear or reset drops it.
    run(8'h00, 10'h010, 4'hB);
    run(8'h00, 10'h3FF, 4'hB);
    chk("sticky flag", 1, window_hit_flag);
    bus(1'b1, `OFS_STATUS, 32'h1);
    chk("cleared flag", 0, window_hit_flag);
    bus(1'b1, `OFS_RESULT, 32'h1234);
    bus(1'b0, `OFS_RESULT, 0);
    chk("read-only result", 32'h03FF, rd);
    // With burst off one start takes one sample whatever the repeat field.
    run(8'h01, 10'h155, 4'h9);
    bus(1'b0, `OFS_RESULT, 0);
    chk("single sample result", 32'h0155, rd);
    bus(1'b1, `OFS_POWER, 32'h12);
    pup = 2;
    chk("buffer_low_power", 1, buffer_low_power);
    bus(1'b1, `OFS_CTRL, 32'h2);
    run(8'h01, 10'h001, 4'hA);
    repeat (3) @(posedge hclk);
    chk("power after burst", 0, converter_power);
    bus(1'b1, `OFS_CTRL, 32'h4);
    chk("temp_sensor_on", 1, temp_sensor_on);
    bus(1'b1, `OFS_CTRL, 32'h0);
    chk("temp_sensor_off", 0, temp_sensor_on);
    bus(1'b1, `OFS_STATUS, 32'h0);
    chk("flag kept by zero write", 1, window_hit_flag);
    run(8'h00, 10'h3FF, 4'hB);
    chk("flag before reset", 1, window_hit_flag);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("flag in reset", 0, window_hit_flag);
    hresetn <= 1'b1;
    bus(1'b0, `OFS_RESULT, 0);
    chk("result after reset", 0, rd);
    print_verdict();
  end

  // A hang counts as a mismatch; the full run needs about 1100 cycles.
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    print_verdict();
  end
endmodule : adc_result_accumulate_window_test
`default_nettype wire
